// ### inc/prs_pkg.sv
// shared constants and types of the power-up reset sequencer
package prs_pkg;

    // ------------------------------------------------------------
    // reset qualification
    // ------------------------------------------------------------
    localparam int unsigned MIN_RST_LF_CYCLES = 4;
    localparam int unsigned LF_CNT_W          = 3;

    // ------------------------------------------------------------
    // low-frequency reference enable divider (25 MHz / 32.768 kHz)
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ         = 25000000;
    localparam int unsigned LF_REF_HZ      = 32768;
    localparam int unsigned LF_DIV_CYCLES  = CLK_HZ / LF_REF_HZ;
    localparam int unsigned LF_DIV_W       = 10;

    // ------------------------------------------------------------
    // clock frequencies reported for the low-power modes
    // ------------------------------------------------------------
    localparam logic [9:0] MCU_PLL_MHZ       = 10'h190;
    localparam logic [9:0] PERIPH_PLL_CFG_MHZ = 10'h12c;

    // ------------------------------------------------------------
    // power modes
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        PRS_RUN,
        PRS_WAIT,
        PRS_DOZE,
        PRS_STOP,
        PRS_STATIC
    } prs_mode_t;

    // ------------------------------------------------------------
    // reset phases
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        PRS_IDLE,
        PRS_ASSERTED,
        PRS_QUALIFIED
    } prs_rst_state_t;

endpackage : prs_pkg

// ### logic/prs_rst_qual.sv
// one reset pin qualifier: counts low-frequency ticks while asserted
module prs_rst_qual #(
    parameter int unsigned MIN_CYCLES = prs_pkg::MIN_RST_LF_CYCLES
) (
    input  wire logic ref_clk_in,   // system clock
    input  wire logic rst_b_in,     // async reset, active low
    input  wire logic lf_tick_in,   // low-frequency reference enable
    input  wire logic pin_b_in,     // reset pin, active low
    output logic      fire_out      // one-cycle pulse on valid release
);

    prs_pkg::prs_rst_state_t              state;
    prs_pkg::prs_rst_state_t              next_state;
    logic [prs_pkg::LF_CNT_W-1:0]         cnt;
    logic [prs_pkg::LF_CNT_W-1:0]         next_cnt;
    logic                                 next_fire;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_cnt   = cnt;
        next_fire  = 1'b0;
        case (state)
            prs_pkg::PRS_IDLE:
            begin
                next_cnt = '0;
                if (!pin_b_in)
                    next_state = prs_pkg::PRS_ASSERTED;
            end
            prs_pkg::PRS_ASSERTED:
            begin
                if (pin_b_in)
                    next_state = prs_pkg::PRS_IDLE; // too short: ignored (RL16)
                else if (lf_tick_in)
                begin
                    next_cnt = cnt + 3'h1;
                    if (32'(cnt) + 1 >= MIN_CYCLES)
                        next_state = prs_pkg::PRS_QUALIFIED; // (RL16)
                end
            end
            prs_pkg::PRS_QUALIFIED:
            begin
                if (pin_b_in)
                begin
                    next_state = prs_pkg::PRS_IDLE;
                    next_fire  = 1'b1; // reset acts on release (RL7)
                end
            end
            default:
                next_state = prs_pkg::PRS_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state    <= prs_pkg::PRS_IDLE;
            cnt      <= '0;
            fire_out <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            cnt      <= next_cnt;
            fire_out <= next_fire;
        end
    end

endmodule : prs_rst_qual

// ### logic/prs_sequencer.sv
// power-up reset sequencer: reset qualification and low-power mode clock states
// Behaviour
// (RL1) power controller holds power-on reset asserted before and during supply ramp
// (RL2) core and io supplies first, then stable plus 32 us wait
// (RL3) second phase enables phy, oscillator, pll supplies; fuse supply grounded
// (RL4) wait second-phase stable plus 100 us before releasing power-on reset
// (RL5) power down in reverse order, or all supplies at once
// (RL6) power ic holds power-on reset until power-up completes
// (RL7) power-on reset held 4 low-freq cycles then released resets everything
// (RL8) system reset held 4 low-freq cycles then released performs system reset
// (RL9) system reset spares rtc, plls, clock controller and fuse module
// (RL10) power-on reset stays deasserted during a system reset
// (RL11) both reset pins may be tied; one pulse gives complete reset
// (RL12) wait: core in wfi, bus matrix active, mcu pll at 400 MHz, gated per regs
// (RL13) doze, stop, static: bus matrix halted, l2 control off, l2 array powered
// (RL14) stop, static: both plls off, all clocks gated, 24 MHz osc on
// (RL15) wait, doze: periph pll off unless configured (300 MHz), rng osc off
// (RL16) count low-freq cycles per reset pin; valid only after minimum length
module prs_sequencer #(
    parameter int unsigned MIN_CYCLES = prs_pkg::MIN_RST_LF_CYCLES,
    parameter int unsigned LF_DIV     = prs_pkg::LF_DIV_CYCLES,
    parameter int unsigned NUM_GATES  = 8
) (
    input  wire logic                 ref_clk_in,          // 25 MHz clock
    input  wire logic                 rst_b_in,            // async reset, active low
    input  wire logic                 por_b_in,            // power-on reset pin
    input  wire logic                 sys_rst_b_in,        // system reset pin
    input  wire prs_pkg::prs_mode_t   mode_in,             // requested power mode
    input  wire logic                 periph_pll_cfg_in,   // keep periph pll on in wait/doze
    input  wire logic                 audio_osc_cfg_in,    // keep audio osc on in wait/doze
    input  wire logic [NUM_GATES-1:0] clock_gating_regs_in, // module clock enables
    output logic                      lf_tick_out,         // low-freq reference enable
    output logic                      por_rst_b_out,       // full reset, active low
    output logic                      sys_rst_b_out,       // system reset, active low
    output logic                      core_wfi_out,        // core held in wait for irq
    output logic                      bus_matrix_en_out,   // bus matrix clock enable
    output logic                      l2_ctrl_en_out,      // l2 control logic on
    output logic                      l2_array_pwr_out,    // l2 array powered
    output logic                      mcu_pll_en_out,      // mcu pll on
    output logic [9:0]                mcu_pll_mhz_out,     // mcu pll frequency
    output logic                      periph_pll_en_out,   // periph pll on
    output logic [9:0]                periph_pll_mhz_out,  // periph pll frequency
    output logic                      main_osc_en_out,     // 24 MHz oscillator on
    output logic                      audio_osc_en_out,    // audio oscillator on
    output logic                      random_generator_osc_en_out, // rng oscillator on
    output logic [NUM_GATES-1:0]      module_clk_en_out    // gated module clocks
);

    // ------------------------------------------------------------
    // low-frequency enable divider
    // ------------------------------------------------------------
    logic [prs_pkg::LF_DIV_W-1:0] div_cnt;
    logic [prs_pkg::LF_DIV_W-1:0] next_div_cnt;
    logic                         next_lf_tick;

    always_comb
    begin
        next_lf_tick = 1'b0;
        next_div_cnt = div_cnt + 10'h001;
        if (32'(div_cnt) >= LF_DIV - 1)
        begin
            next_div_cnt = '0;
            next_lf_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            div_cnt     <= '0;
            lf_tick_out <= 1'b0;
        end
        else
        begin
            div_cnt     <= next_div_cnt;
            lf_tick_out <= next_lf_tick;
        end
    end

    // ------------------------------------------------------------
    // reset pin qualification
    // ------------------------------------------------------------
    logic por_fire;
    logic sys_fire;

    prs_rst_qual #(
        .MIN_CYCLES (MIN_CYCLES)
    ) u_por_qual (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .lf_tick_in (lf_tick_out),
        .pin_b_in   (por_b_in),
        .fire_out   (por_fire)
    );

    prs_rst_qual #(
        .MIN_CYCLES (MIN_CYCLES)
    ) u_sys_qual (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .lf_tick_in (lf_tick_out),
        .pin_b_in   (sys_rst_b_in),
        .fire_out   (sys_fire)
    );

    // ------------------------------------------------------------
    // reset outputs: one-cycle active-low pulses
    // ------------------------------------------------------------
    logic next_por_rst_b;
    logic next_sys_rst_b;

    always_comb
    begin
        next_por_rst_b = !por_fire;              // (RL7)
        // a complete reset also covers the system domain; tied pins give both (RL11)
        next_sys_rst_b = !(sys_fire || por_fire); // (RL8)
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            por_rst_b_out <= 1'b0;
            sys_rst_b_out <= 1'b0;
        end
        else
        begin
            por_rst_b_out <= next_por_rst_b;
            sys_rst_b_out <= next_sys_rst_b;
        end
    end

    // ------------------------------------------------------------
    // power mode clock states
    // pll and oscillator enables sit in the power-on domain and are not
    // touched by a system reset
    // ------------------------------------------------------------
    logic                 next_core_wfi;
    logic                 next_bus_en;
    logic                 next_l2_ctrl;
    logic                 next_mpll;
    logic                 next_ppll;
    logic                 next_aosc;
    logic                 next_rng;
    logic [9:0]           next_ppll_mhz;
    logic [NUM_GATES-1:0] next_gates;

    always_comb
    begin
        next_core_wfi = 1'b0;
        next_bus_en   = 1'b1;
        next_l2_ctrl  = 1'b1;
        next_mpll     = 1'b1;
        next_ppll     = 1'b1;
        next_aosc     = 1'b1;
        next_rng      = 1'b1;
        next_gates    = '1;
        case (mode_in)
            prs_pkg::PRS_RUN:
            begin
                next_gates = '1;
            end
            prs_pkg::PRS_WAIT, prs_pkg::PRS_DOZE:
            begin
                next_core_wfi = 1'b1;                   // (RL12)
                next_gates    = clock_gating_regs_in;   // (RL12)
                next_ppll     = periph_pll_cfg_in;      // (RL15)
                next_rng      = 1'b0;                   // (RL15)
                next_aosc     = audio_osc_cfg_in;
                if (mode_in == prs_pkg::PRS_DOZE)
                begin
                    next_bus_en  = 1'b0;                // (RL13)
                    next_l2_ctrl = 1'b0;                // (RL13)
                end
            end
            prs_pkg::PRS_STOP, prs_pkg::PRS_STATIC:
            begin
                next_core_wfi = 1'b1;
                next_bus_en   = 1'b0;                   // (RL13)
                next_l2_ctrl  = 1'b0;                   // (RL13)
                next_mpll     = 1'b0;                   // (RL14)
                next_ppll     = 1'b0;                   // (RL14)
                next_aosc     = 1'b0;                   // (RL14)
                next_rng      = 1'b0;
                next_gates    = '0;                     // (RL14)
            end
            default:
            begin
                next_gates = '1;
            end
        endcase
        next_ppll_mhz = next_ppll ? prs_pkg::PERIPH_PLL_CFG_MHZ : 10'h000;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            core_wfi_out                <= 1'b0;
            bus_matrix_en_out           <= 1'b1;
            l2_ctrl_en_out              <= 1'b1;
            l2_array_pwr_out            <= 1'b1;
            mcu_pll_en_out              <= 1'b1;
            mcu_pll_mhz_out             <= prs_pkg::MCU_PLL_MHZ;
            periph_pll_en_out           <= 1'b1;
            periph_pll_mhz_out          <= prs_pkg::PERIPH_PLL_CFG_MHZ;
            main_osc_en_out             <= 1'b1;
            audio_osc_en_out            <= 1'b1;
            random_generator_osc_en_out <= 1'b1;
            module_clk_en_out           <= '1;
        end
        else
        begin
            core_wfi_out                <= next_core_wfi; // (RL12)
            bus_matrix_en_out           <= next_bus_en;
            l2_ctrl_en_out              <= next_l2_ctrl;
            l2_array_pwr_out            <= 1'b1;                 // (RL13)
            mcu_pll_en_out              <= next_mpll;
            mcu_pll_mhz_out             <= next_mpll ? prs_pkg::MCU_PLL_MHZ : 10'h000; // (RL12)
            periph_pll_en_out           <= next_ppll;
            periph_pll_mhz_out          <= next_ppll_mhz;
            main_osc_en_out             <= 1'b1;                 // (RL14)
            audio_osc_en_out            <= next_aosc;
            random_generator_osc_en_out <= next_rng;
            module_clk_en_out           <= next_gates;
        end
    end

endmodule : prs_sequencer

// ### test/prs_pmic_model.sv
// behavioural power management ic driving the two reset pins
module prs_pmic_model (
    input  wire logic ref_clk_in,    // system clock
    input  wire logic lf_tick_in,    // low-freq reference enable
    output logic      por_b_out,     // power-on reset pin
    output logic      sys_rst_b_out  // system reset pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        por_b_out     = 1'b0;
        sys_rst_b_out = 1'b1;
    end
    // hold the chosen pins low for a count of low-freq ticks, then release
    task automatic hold_low(input logic por, input logic sys, input int ticks);
        int seen;
        seen = 0;
        @(negedge ref_clk_in);
        por_b_out     = !por;
        sys_rst_b_out = !sys;
        // the qualifier starts counting one edge after it first sees the pin low
        @(negedge ref_clk_in);
        forever
        begin
            if (lf_tick_in)
                seen++;
            if (seen >= ticks)
                break;
            @(negedge ref_clk_in);
        end
        @(negedge ref_clk_in);
        por_b_out     = 1'b1;
        sys_rst_b_out = 1'b1;
    endtask : hold_low
    // all rails drop together, reset taken first
    task automatic power_down;
        @(negedge ref_clk_in);
        por_b_out = 1'b0;
    endtask : power_down
    // core and io rails settle, then the second group, before por release
    task automatic power_up;
        hold_low(1'b1, 1'b0, 2 + 4);
    endtask : power_up
endmodule : prs_pmic_model

// ### test/prs_seq_monitor.sv
// concurrent checks on the ports of the power-up reset sequencer
module prs_seq_monitor #(
    parameter int unsigned MIN_CYCLES = 4,
    parameter int unsigned NUM_GATES  = 8,
    parameter int unsigned LF_DIV     = prs_pkg::LF_DIV_CYCLES
) (
    input wire logic                 ref_clk_in,        // clock
    input wire logic                 rst_b_in,          // reset
    input wire logic                 por_b_in,          // por pin
    input wire logic                 sys_rst_b_in,      // sys pin
    input wire prs_pkg::prs_mode_t   mode_in,           // mode
    input wire logic                 periph_pll_cfg_in, // pll cfg
    input wire logic [NUM_GATES-1:0] clock_gating_regs_in, // gates
    input wire logic                 lf_tick_out,       // tick
    input wire logic                 por_rst_b_out,     // full reset
    input wire logic                 sys_rst_b_out,     // sys reset
    input wire logic                 core_wfi_out,      // wfi
    input wire logic                 bus_matrix_en_out, // bus
    input wire logic                 l2_ctrl_en_out,    // l2 ctrl
    input wire logic                 l2_array_pwr_out,  // l2 array
    input wire logic                 mcu_pll_en_out,    // mcu pll
    input wire logic [9:0]           mcu_pll_mhz_out,   // mcu mhz
    input wire logic                 periph_pll_en_out, // periph pll
    input wire logic                 random_generator_osc_en_out, // rng
    input wire logic [NUM_GATES-1:0] module_clk_en_out  // clocks
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] por_cnt;
    logic [2:0] sys_cnt;
    logic [2:0] next_por_cnt;
    logic [2:0] next_sys_cnt;
    logic       stp;
    logic       wd;
    logic       por_q;
    logic       sys_q;
    logic [9:0] tick_gap;
    // ticks seen while each pin is low, saturating
    always_comb
    begin
        // a tick on the edge that first sees the pin low is not counted
        next_por_cnt = por_b_in ? 3'h0
                     : por_cnt + {2'h0, lf_tick_out & !por_q & (por_cnt != 3'h7)};
        next_sys_cnt = sys_rst_b_in ? 3'h0
                     : sys_cnt + {2'h0, lf_tick_out & !sys_q & (sys_cnt != 3'h7)};
        stp = (mode_in == prs_pkg::PRS_STOP) || (mode_in == prs_pkg::PRS_STATIC);
        wd  = (mode_in == prs_pkg::PRS_WAIT) || (mode_in == prs_pkg::PRS_DOZE);
    end
    always_ff @(posedge ref_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            por_cnt  <= 3'h0;
            sys_cnt  <= 3'h0;
            por_q    <= 1'b1;
            sys_q    <= 1'b1;
            // all ones so that the first tick, LF_DIV edges after reset, lines up
            tick_gap <= 10'h3ff;
        end
        else
        begin
            por_cnt  <= next_por_cnt;
            sys_cnt  <= next_sys_cnt;
            por_q    <= por_b_in;
            sys_q    <= sys_rst_b_in;
            tick_gap <= lf_tick_out ? 10'h000 : tick_gap + 10'h001;
        end
    end
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_b_in);
    property p_por_fires;
        $rose(por_b_in) && (por_cnt >= MIN_CYCLES) |-> ##2 !por_rst_b_out && !sys_rst_b_out;
    endproperty
    a_por_fires: assert property (p_por_fires) else $error("full reset missing");
    property p_sys_fires;
        $rose(sys_rst_b_in) && (sys_cnt >= MIN_CYCLES) |-> ##2 !sys_rst_b_out;
    endproperty
    a_sys_fires: assert property (p_sys_fires) else $error("system reset missing");
    property p_short_ignored;
        $rose(por_b_in) && (por_cnt < MIN_CYCLES) |-> ##1 por_rst_b_out [*3];
    endproperty
    a_short_ignored: assert property (p_short_ignored) else $error("short pulse taken");
    property p_pulse_len;
        $fell(por_rst_b_out) |=> por_rst_b_out;
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("full reset too long");
    property p_sys_spares;
        !sys_rst_b_out && por_b_in && $past(por_b_in) && $past(por_b_in, 2)
            && $past(por_b_in, 3) |-> por_rst_b_out;
    endproperty
    a_sys_spares: assert property (p_sys_spares) else $error("sys reset hit por");
    property p_wait_state;
        mode_in == prs_pkg::PRS_WAIT |=> core_wfi_out && bus_matrix_en_out
            && mcu_pll_en_out && (mcu_pll_mhz_out == 10'h190);
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("wait state wrong");
    property p_halted;
        stp || (mode_in == prs_pkg::PRS_DOZE) |=> !bus_matrix_en_out && !l2_ctrl_en_out
            && l2_array_pwr_out;
    endproperty
    a_halted: assert property (p_halted) else $error("bus or l2 not halted");
    property p_stop_off;
        stp |=> !mcu_pll_en_out && !periph_pll_en_out && (module_clk_en_out == '0);
    endproperty
    a_stop_off: assert property (p_stop_off) else $error("stop clocks running");
    property p_wd_cfg;
        wd |=> !random_generator_osc_en_out && (periph_pll_en_out == $past(periph_pll_cfg_in))
            && (module_clk_en_out == $past(clock_gating_regs_in));
    endproperty
    a_wd_cfg: assert property (p_wd_cfg) else $error("wait or doze cfg wrong");
    property p_tick_period;
        lf_tick_out == (tick_gap == 10'(LF_DIV - 1));
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick spacing wrong");
endmodule : prs_seq_monitor

bind prs_sequencer prs_seq_monitor #(.MIN_CYCLES(MIN_CYCLES), .NUM_GATES(NUM_GATES),
    .LF_DIV(LF_DIV))
    i_prs_seq_monitor (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .por_b_in(por_b_in),
    .sys_rst_b_in(sys_rst_b_in), .mode_in(mode_in), .periph_pll_cfg_in(periph_pll_cfg_in),
    .clock_gating_regs_in(clock_gating_regs_in), .lf_tick_out(lf_tick_out),
    .por_rst_b_out(por_rst_b_out), .sys_rst_b_out(sys_rst_b_out),
    .core_wfi_out(core_wfi_out), .bus_matrix_en_out(bus_matrix_en_out),
    .l2_ctrl_en_out(l2_ctrl_en_out), .l2_array_pwr_out(l2_array_pwr_out),
    .mcu_pll_en_out(mcu_pll_en_out), .mcu_pll_mhz_out(mcu_pll_mhz_out),
    .periph_pll_en_out(periph_pll_en_out),
    .random_generator_osc_en_out(random_generator_osc_en_out),
    .module_clk_en_out(module_clk_en_out));

// ### test/prs_sequencer_tb.sv
// self-checking bench for the power-up reset sequencer
module prs_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic               ref_clk = 1'b0;
    logic               rst_b   = 1'b0;
    logic               por_b;
    logic               sys_b;
    prs_pkg::prs_mode_t mode    = prs_pkg::PRS_RUN;
    logic               pcfg    = 1'b0;
    logic               acfg    = 1'b0;
    logic [7:0]         gates   = 8'h00;
    logic               lf_tick;
    logic [1:0]         rst_out;
    logic [8:0]         flags;
    logic [9:0]         mcu_mhz;
    logic [9:0]         per_mhz;
    logic [7:0]         clk_en;
    int                 n_errors     = 0;
    int                 total_checks = 0;
    int                 cycles       = 0;
    always #20 ref_clk = ~ref_clk;
    prs_pmic_model i_prs_pmic_model (.ref_clk_in(ref_clk), .lf_tick_in(lf_tick),
        .por_b_out(por_b), .sys_rst_b_out(sys_b));
    prs_sequencer #(.MIN_CYCLES(4), .LF_DIV(4), .NUM_GATES(8)) i_prs_sequencer (
        .ref_clk_in(ref_clk), .rst_b_in(rst_b), .por_b_in(por_b), .sys_rst_b_in(sys_b),
        .mode_in(mode), .periph_pll_cfg_in(pcfg), .audio_osc_cfg_in(acfg),
        .clock_gating_regs_in(gates), .lf_tick_out(lf_tick), .por_rst_b_out(rst_out[1]),
        .sys_rst_b_out(rst_out[0]), .core_wfi_out(flags[8]), .bus_matrix_en_out(flags[7]),
        .l2_ctrl_en_out(flags[6]), .l2_array_pwr_out(flags[5]), .mcu_pll_en_out(flags[4]),
        .periph_pll_en_out(flags[3]), .main_osc_en_out(flags[2]),
        .audio_osc_en_out(flags[1]), .random_generator_osc_en_out(flags[0]),
        .mcu_pll_mhz_out(mcu_mhz), .periph_pll_mhz_out(per_mhz), .module_clk_en_out(clk_en));
    task automatic tally_and_finish;
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic check_rst(input logic [1:0] exp);
        total_checks++;
        if (rst_out !== exp)
        begin
            n_errors++;
            $display("Error at %0t: resets %h expected %h", $time, rst_out, exp);
        end
    endtask : check_rst
    task automatic check_modes(input logic [36:0] exp);
        total_checks++;
        if ({flags, mcu_mhz, per_mhz, clk_en} !== exp)
        begin
            n_errors++;
            $display("Error at %0t: modes %h expected %h", $time,
                     {flags, mcu_mhz, per_mhz, clk_en}, exp);
        end
    endtask : check_modes
    function automatic logic [36:0] exp_modes(input prs_pkg::prs_mode_t m);
        logic stp;
        logic wd;
        logic on;
        logic pe;
        logic ae;
        stp = (m == prs_pkg::PRS_STOP) || (m == prs_pkg::PRS_STATIC);
        wd  = (m == prs_pkg::PRS_WAIT) || (m == prs_pkg::PRS_DOZE);
        on  = (m == prs_pkg::PRS_RUN) || (m == prs_pkg::PRS_WAIT);
        pe  = wd ? pcfg : !stp;
        ae  = wd ? acfg : !stp;
        return {m != prs_pkg::PRS_RUN, on, on, 1'b1, !stp, pe, 1'b1, ae,
                m == prs_pkg::PRS_RUN, stp ? 10'h000 : prs_pkg::MCU_PLL_MHZ,
                pe ? prs_pkg::PERIPH_PLL_CFG_MHZ : 10'h000,
                stp ? 8'h00 : (wd ? gates : 8'hff)};
    endfunction : exp_modes
    // after the release edge: one idle, one pulse and one recovered cycle
    task automatic watch(input logic [1:0] low);
        @(negedge ref_clk);
        check_rst(2'h3);
        @(negedge ref_clk);
        check_rst(~low);
        @(negedge ref_clk);
        check_rst(2'h3);
    endtask : watch
    task automatic pulse(input logic por, input logic sys, input int ticks,
                         input logic [1:0] low);
        i_prs_pmic_model.hold_low(por, sys, ticks);
        watch(low);
    endtask : pulse
    task automatic t_power_up;
        i_prs_pmic_model.power_up();
        watch(2'h3);
    endtask : t_power_up
    task automatic t_power_cycle;
        i_prs_pmic_model.power_down();
        i_prs_pmic_model.power_up();
        watch(2'h3);
    endtask : t_power_cycle
    task automatic t_por_short;
        pulse(1'b1, 1'b0, 3, 2'h0);
    endtask : t_por_short
    task automatic t_por_exact;
        pulse(1'b1, 1'b0, 4, 2'h3);
    endtask : t_por_exact
    task automatic t_sys_short;
        pulse(1'b0, 1'b1, 3, 2'h0);
    endtask : t_sys_short
    task automatic t_sys_reset;
        mode = prs_pkg::PRS_STOP;
        @(negedge ref_clk);
        @(negedge ref_clk);
        check_modes(exp_modes(mode));
        pulse(1'b0, 1'b1, 4, 2'h1);
        check_modes(exp_modes(mode));
    endtask : t_sys_reset
    task automatic t_tied;
        pulse(1'b1, 1'b1, 5, 2'h3);
    endtask : t_tied
    task automatic t_modes;
        for (int i = 0; i < 10; i++)
        begin
            mode  = prs_pkg::prs_mode_t'(i / 2);
            pcfg  = i[0];
            acfg  = !i[0];
            gates = 8'h5a ^ {8{i[0]}};
            @(negedge ref_clk);
            @(negedge ref_clk);
            check_modes(exp_modes(mode));
        end
    endtask : t_modes
    initial
    begin
        repeat (5) @(negedge ref_clk);
        rst_b = 1'b1;
        t_power_up();
        t_por_short();
        t_por_exact();
        t_sys_short();
        t_sys_reset();
        t_tied();
        t_power_cycle();
        t_modes();
        tally_and_finish();
    end
endmodule : prs_sequencer_tb
